// >>> hdl/acpl_top.sv
// Control-pin logic of a six-input sigma-delta converter with serial result port
//
// How it works
// - Edge sense low: first serial clock transition is low to high.
// - Edge sense high: first serial clock transition is high to low.
// - Continuous or burst serial clocking both transfer data correctly.
// - Filter-align low holds filter, filter control, calibration and modulator reset.
// - Filter-align leaves serial logic alone and never raises a low ready.
// - Reset low returns all control, interface, filter and modulator state.
// - Sleep request low shuts down analog and digital circuitry.
// - Buffer select low bypasses input buffer; high puts it in series.
// - Master clock output is the inverted master clock.
// - Operation specified at 1 MHz and 2.4576 MHz master clock.
// - Pairs 1/2, 3/4, 5/6; pseudo mode references inputs 1-5 to six.
// - Word ready falls on new result, rises after full word read.
// - Active serial edge is falling with edge sense high, rising otherwise.
// - Serial port responds only while select is low; may be tied low.
`timescale 1ns/1ps
`default_nettype none

module acpl_top #(
  parameter int WORD_W = acpl_pkg::RESULT_BITS,
  parameter int MCLK_HZ = acpl_pkg::MCLK_HIGH_HZ
) (
  // Master clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  output logic mclk_out_o,
  // Serial link
  input wire logic serial_clk_i,
  input wire logic edge_sense_select_i,
  input wire logic select_n_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic word_ready_n_o,
  // Control pins
  input wire logic filter_align_n_i,
  input wire logic sleep_req_n_i,
  input wire logic buffer_sel_i,
  // Result from filter
  input wire logic [WORD_W-1:0] result_word_i,
  input wire logic result_strobe_i,
  // Channel selection
  input wire logic pseudo_diff_i,
  input wire logic [acpl_pkg::SEL_W-1:0] chan_sel_i,
  output acpl_pkg::acpl_chan_t mux_pos_o,
  output acpl_pkg::acpl_chan_t mux_neg_o,
  // Reset, power and buffer outputs to the converter core
  output logic filter_reset_o,
  output logic filter_ctrl_reset_o,
  output logic cal_reset_o,
  output logic modulator_reset_o,
  output logic analog_shutdown_o,
  output logic digital_shutdown_o,
  output logic buffer_bypass_o
);
  import acpl_pkg::*;

  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_W - 1);
  localparam bit MCLK_SPEC_OK = (MCLK_HZ == MCLK_LOW_HZ) || (MCLK_HZ == MCLK_HIGH_HZ);

  // ==================================================================
  // Master clock output
  // inverted clock out
  assign mclk_out_o = ~clk_sys_i;

  // ==================================================================
  // Pin and read toggle synchronisers on the master clock
  logic [3:0] pin_sync;
  logic read_tgl;
  wire align_q = pin_sync[3];
  wire awake_q = pin_sync[2];
  wire buf_q = pin_sync[1];
  wire read_tgl_s = pin_sync[0];

  acpl_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .async_i({filter_align_n_i, sleep_req_n_i, buffer_sel_i, read_tgl}),
    .sync_o(pin_sync)
  );

  // ==================================================================
  // Result capture and word ready
  logic read_tgl_d;
  logic word_tgl;
  logic [WORD_W-1:0] word_hold;
  logic next_ready_n;
  wire read_evt = read_tgl_s ^ read_tgl_d;
  wire accept = result_strobe_i & awake_q & align_q;

  assign next_ready_n = accept ? 1'b0 : (read_evt ? 1'b1 : word_ready_n_o);

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      read_tgl_d <= BIT_CLEAR;
      word_tgl <= BIT_CLEAR;
      word_hold <= '0;
      word_ready_n_o <= READY_IDLE;
    end
    else
    begin
      read_tgl_d <= read_tgl_s;
      word_ready_n_o <= next_ready_n;
      if (accept)
      begin
        word_hold <= result_word_i;
        word_tgl <= ~word_tgl;
      end
    end
  end

  // ==================================================================
  // Filter, modulator, power and buffer control
  // hold while aligning or asleep
  wire next_hold = ~align_q | ~awake_q;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      filter_reset_o <= HOLD_ON;
      filter_ctrl_reset_o <= HOLD_ON;
      cal_reset_o <= HOLD_ON;
      modulator_reset_o <= HOLD_ON;
      analog_shutdown_o <= HOLD_ON;
      digital_shutdown_o <= HOLD_ON;
      buffer_bypass_o <= HOLD_ON;
    end
    else
    begin
      filter_reset_o <= next_hold;
      filter_ctrl_reset_o <= next_hold;
      cal_reset_o <= next_hold;
      modulator_reset_o <= next_hold;
      analog_shutdown_o <= ~awake_q;
      digital_shutdown_o <= ~awake_q;
      buffer_bypass_o <= ~buf_q;
    end
  end

  // ==================================================================
  // Channel multiplexer
  // channel pairing
  wire acpl_chan_t diff_pos = (chan_sel_i == SEL_PAIR_12) ? ANALOG_CHANNEL_ONE :
    (chan_sel_i == SEL_PAIR_34) ? ANALOG_CHANNEL_THREE : ANALOG_CHANNEL_FIVE;
  wire acpl_chan_t diff_neg = (chan_sel_i == SEL_PAIR_12) ? ANALOG_CHANNEL_TWO :
    (chan_sel_i == SEL_PAIR_34) ? ANALOG_CHANNEL_FOUR : ANALOG_CHANNEL_SIX;
  wire acpl_chan_t pseudo_pos = (chan_sel_i == SEL_PSEUDO_1) ? ANALOG_CHANNEL_ONE :
    (chan_sel_i == SEL_PSEUDO_2) ? ANALOG_CHANNEL_TWO :
    (chan_sel_i == SEL_PSEUDO_3) ? ANALOG_CHANNEL_THREE :
    (chan_sel_i == SEL_PSEUDO_4) ? ANALOG_CHANNEL_FOUR : ANALOG_CHANNEL_FIVE;
  wire acpl_chan_t next_pos = pseudo_diff_i ? pseudo_pos : diff_pos;
  wire acpl_chan_t next_neg = pseudo_diff_i ? ANALOG_CHANNEL_SIX : diff_neg;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mux_pos_o <= ANALOG_CHANNEL_ONE;
      mux_neg_o <= ANALOG_CHANNEL_TWO;
    end
    else
    begin
      mux_pos_o <= next_pos;
      mux_neg_o <= next_neg;
    end
  end

  // ==================================================================
  // Serial link domain
  // active edge made rising
  wire link_clk = serial_clk_i ^ edge_sense_select_i;

  logic word_tgl_s;
  logic word_tgl_d;
  logic [WORD_W-1:0] word_buf;
  logic [WORD_W-1:0] shift;
  logic [CNT_W-1:0] bit_count;
  acpl_link_e state;
  wire new_word = word_tgl_s ^ word_tgl_d;

  acpl_sync #(
    .WIDTH(1)
  ) u_word_sync (
    .clk_i(link_clk),
    .rst_b_i(rst_b_i),
    .async_i(word_tgl),
    .sync_o(word_tgl_s)
  );

  assign dout_oe_o = ~select_n_i;
  assign dout_o = (state == LINK_IDLE) ? word_buf[WORD_W-1] : shift[WORD_W-1];

  always_ff @(posedge link_clk or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      word_tgl_d <= BIT_CLEAR;
      word_buf <= '0;
    end
    else
    begin
      word_tgl_d <= word_tgl_s;
      if (new_word)
      begin
        word_buf <= word_hold;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= LINK_IDLE;
      bit_count <= CNT_ZERO;
      shift <= '0;
      read_tgl <= BIT_CLEAR;
    end
    else if (select_n_i)
    begin
      state <= LINK_IDLE;
      bit_count <= CNT_ZERO;
    end
    else
    begin
      case (state)
        LINK_IDLE:
        begin
          state <= LINK_SHIFT;
          shift <= word_buf << 1;
          bit_count <= CNT_ONE;
        end
        LINK_SHIFT:
        begin
          if (bit_count == LAST_BIT)
          begin
            state <= LINK_IDLE;
            bit_count <= CNT_ZERO;
            read_tgl <= ~read_tgl;
          end
          else
          begin
            shift <= shift << 1;
            bit_count <= bit_count + CNT_ONE;
          end
        end
        default:
        begin
          state <= LINK_IDLE;
        end
      endcase
    end
  end

  // ==================================================================
  // Checks on the master clock domain
  sequence s_new_word;
    accept ##1 !word_ready_n_o;
  endsequence

  sequence s_read_done;
    (read_evt && !accept) ##1 word_ready_n_o;
  endsequence

  a_hold_filter: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !align_q |=> (filter_reset_o && filter_ctrl_reset_o && cal_reset_o && modulator_reset_o))
    else $error("filter not held while aligning");
  a_align_keeps_ready: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!word_ready_n_o && !read_evt) |=> !word_ready_n_o)
    else $error("ready rose without a read");
  a_ready_on_word: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    accept |-> s_new_word)
    else $error("ready not low after new word");
  a_ready_after_read: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (read_evt && !accept) |-> s_read_done)
    else $error("ready not high after word read");
  a_sleep_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !awake_q |-> (!accept ##1 (analog_shutdown_o && digital_shutdown_o && filter_reset_o)))
    else $error("sleep did not shut down");
  a_buffer_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    ##1 (buffer_bypass_o == !$past(buf_q)))
    else $error("buffer bypass wrong");

  a_pair_diff: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!pseudo_diff_i && chan_sel_i == SEL_PAIR_34)
    |=> (mux_pos_o == ANALOG_CHANNEL_THREE && mux_neg_o == ANALOG_CHANNEL_FOUR))
    else $error("differential pair wrong");

  a_pseudo_ref: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (pseudo_diff_i && chan_sel_i <= SEL_PSEUDO_4) |=> (mux_neg_o == ANALOG_CHANNEL_SIX))
    else $error("pseudo reference not channel six");

  a_reset_state: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |-> (word_ready_n_o && filter_reset_o && analog_shutdown_o))
    else $error("not in power-on state after reset");

  a_mclk_spec: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    MCLK_SPEC_OK)
    else $error("master clock rate outside specified figures");

  // ==================================================================
  // Checks on the link domain
  sequence s_last_bit;
    (!select_n_i && state == LINK_SHIFT && bit_count == LAST_BIT) ##1 (bit_count == CNT_ZERO);
  endsequence

  a_frame_idle: assert property (@(posedge link_clk) disable iff (!rst_b_i)
    select_n_i |=> (state == LINK_IDLE && bit_count == CNT_ZERO))
    else $error("link moved while deselected");

  a_bit_step: assert property (@(posedge link_clk) disable iff (!rst_b_i)
    (!select_n_i && state == LINK_SHIFT && bit_count != LAST_BIT)
    |=> (bit_count == $past(bit_count) + CNT_ONE))
    else $error("bit count did not advance");

  a_word_done: assert property (@(posedge link_clk) disable iff (!rst_b_i)
    s_last_bit |-> (read_tgl != $past(read_tgl)))
    else $error("word end not signalled");

endmodule

`default_nettype wire

// >>> pkg/acpl_pkg.sv
// Constants and types shared by the converter control-pin logic
package acpl_pkg;

  // ==================================================================
  // Result word and link counter
  localparam int RESULT_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

  // ==================================================================
  // Master clock figures the part is specified at
  localparam int MCLK_LOW_HZ = 1_000_000;
  localparam int MCLK_HIGH_HZ = 2_457_600;

  // ==================================================================
  // Channel select codes and one-hot analog channel lines
  localparam int CHAN_COUNT = 6;
  localparam int SEL_W = 3;
  typedef logic [CHAN_COUNT-1:0] acpl_chan_t;
  localparam logic [SEL_W-1:0] SEL_PAIR_12 = 3'h0;
  localparam logic [SEL_W-1:0] SEL_PAIR_34 = 3'h1;
  localparam logic [SEL_W-1:0] SEL_PSEUDO_1 = 3'h0;
  localparam logic [SEL_W-1:0] SEL_PSEUDO_2 = 3'h1;
  localparam logic [SEL_W-1:0] SEL_PSEUDO_3 = 3'h2;
  localparam logic [SEL_W-1:0] SEL_PSEUDO_4 = 3'h3;
  localparam acpl_chan_t ANALOG_CHANNEL_ONE = 6'h01;
  localparam acpl_chan_t ANALOG_CHANNEL_TWO = 6'h02;
  localparam acpl_chan_t ANALOG_CHANNEL_THREE = 6'h04;
  localparam acpl_chan_t ANALOG_CHANNEL_FOUR = 6'h08;
  localparam acpl_chan_t ANALOG_CHANNEL_FIVE = 6'h10;
  localparam acpl_chan_t ANALOG_CHANNEL_SIX = 6'h20;

  // ==================================================================
  // Reset levels
  localparam logic HOLD_ON = 1'b1;
  localparam logic READY_IDLE = 1'b1;
  localparam logic BIT_CLEAR = 1'b0;

  // ==================================================================
  // Serial link states
  typedef enum logic {LINK_IDLE, LINK_SHIFT} acpl_link_e;

endpackage

// >>> hdl/acpl_sync.sv
// Two-stage synchroniser for a group of level or toggle signals
`timescale 1ns/1ps
`default_nettype none

module acpl_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Signals
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage_one;

  // ==================================================================
  // Synchronising chain
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stage_one <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end

endmodule

`default_nettype wire

// >>> bench/acpl_host.sv
// Serial host model that clocks result words out of the converter
`timescale 1ns/1ps
`default_nettype none

module acpl_host (
  // Link pins
  input wire logic pol_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic sel_n_o
);
  initial
  begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
  end

  // ==================================================================
  // Idle level
  // clock rests at polarity level
  task automatic park(input logic p);
    sclk_o = p;
  endtask

  // ==================================================================
  // Frame of n clock cycles, paused once after the twelfth
  // sample before each active edge
  task automatic frame(input int n, input logic desel, input int gap, output logic [23:0] d);
    d = 24'h000000;
    sel_n_o = desel;
    #40;
    for (int i = 0; i < n; i++)
    begin
      d = {d[22:0], dout_i};
      sclk_o = ~pol_i;
      #16;
      sclk_o = pol_i;
      #16;
      if (i == 11)
        #(gap);
    end
    #40;
    sel_n_o = 1'b1;
  endtask
endmodule

`default_nettype wire

// >>> bench/acpl_top_tb.sv
// Self-checking testbench of the converter control-pin logic
`timescale 1ns/1ps
`default_nettype none

module acpl_top_tb;
  import acpl_pkg::*;
  logic clk_sys_i, rst_b_i, edge_sense_select, align_n, sleep_n, buf_sel, strobe, pseudo;
  logic [2:0] chan;
  logic [23:0] word, w;
  logic sclk, sel_n, dout, dout_oe, ready_n, mclk;
  logic f_rst, fc_rst, cal_rst, mod_rst, a_off, d_off, bypass;
  acpl_chan_t pos, neg;
  int mismatches, num_checks;

  acpl_top acpl_top_inst (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mclk_out_o(mclk),
    .serial_clk_i(sclk), .edge_sense_select_i(edge_sense_select), .select_n_i(sel_n),
    .dout_o(dout), .dout_oe_o(dout_oe), .word_ready_n_o(ready_n),
    .filter_align_n_i(align_n), .sleep_req_n_i(sleep_n), .buffer_sel_i(buf_sel),
    .result_word_i(word), .result_strobe_i(strobe),
    .pseudo_diff_i(pseudo), .chan_sel_i(chan), .mux_pos_o(pos), .mux_neg_o(neg),
    .filter_reset_o(f_rst), .filter_ctrl_reset_o(fc_rst), .cal_reset_o(cal_rst),
    .modulator_reset_o(mod_rst), .analog_shutdown_o(a_off),
    .digital_shutdown_o(d_off), .buffer_bypass_o(bypass)
  );

  acpl_host acpl_host_inst (.pol_i(edge_sense_select), .dout_i(dout), .sclk_o(sclk), .sel_n_o(sel_n));

  // ==================================================================
  // Clock and watchdog
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    #400000;
    mismatches++;
    end_of_test();
  end

  // ==================================================================
  // Compare and report
  task automatic check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic check_vec(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==================================================================
  // Expected channel lines
  function automatic logic [11:0] exp_mux(input logic p, input logic [2:0] c);
    case ({p, c})
      4'h0: return {ANALOG_CHANNEL_ONE, ANALOG_CHANNEL_TWO};
      4'h1: return {ANALOG_CHANNEL_THREE, ANALOG_CHANNEL_FOUR};
      4'h8: return {ANALOG_CHANNEL_ONE, ANALOG_CHANNEL_SIX};
      4'h9: return {ANALOG_CHANNEL_TWO, ANALOG_CHANNEL_SIX};
      4'ha: return {ANALOG_CHANNEL_THREE, ANALOG_CHANNEL_SIX};
      4'hb: return {ANALOG_CHANNEL_FOUR, ANALOG_CHANNEL_SIX};
      default: return {ANALOG_CHANNEL_FIVE, ANALOG_CHANNEL_SIX};
    endcase
  endfunction

  // ==================================================================
  // Stimulus tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic put_word(input logic [23:0] v);
    @(posedge clk_sys_i);
    word <= v;
    strobe <= 1'b1;
    @(posedge clk_sys_i);
    strobe <= 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic read_word(input logic [23:0] v);
    logic [23:0] d;
    fork
      acpl_host_inst.frame(4, 1'b1, 0, d);
      #60 check_bit("oe_desel", 1'b0, dout_oe); // not driven deselected
    join
    check_bit("ready_desel", 1'b0, ready_n); // deselected edges ignored
    fork
      acpl_host_inst.frame(24, 1'b0, int'($urandom_range(0, 200)), d);
      #60 check_bit("oe_sel", 1'b1, dout_oe); // driven while selected
    join
    check_vec("word", v, d); // data bits
    for (int i = 0; i < 12 && ready_n !== 1'b1; i++)
      @(negedge clk_sys_i);
    check_bit("ready_read", 1'b1, ready_n); // released after read
  endtask

  task automatic do_reset(input logic p);
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    cyc(8);
    edge_sense_select <= p;
    acpl_host_inst.park(p);
    @(negedge clk_sys_i);
    check_bit("ready_rst", 1'b1, ready_n); // ready idle
    check_bit("filt_rst", 1'b1, f_rst); // filter held
    check_vec("mux_rst", 24'h000042, {12'h000, pos, neg}); // mux state
    @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
  endtask

  // ==================================================================
  // Main sequence
  initial
  begin
    mismatches = 0;
    num_checks = 0;
    void'($urandom(53006));
    rst_b_i = 1'b0;
    {edge_sense_select, align_n, sleep_n, buf_sel, strobe, pseudo} = 6'h3c;
    chan = 3'h0;
    word = 24'h000000;
    for (int p = 0; p < 2; p++)
    begin
      do_reset(p[0]);
      @(posedge clk_sys_i) buf_sel <= 1'($urandom);
      cyc(4);
      @(negedge clk_sys_i);
      check_bit("bypass", ~buf_sel, bypass); // buffer select
      check_bit("filt_run", 1'b0, f_rst); // filter released
      check_bit("a_on", 1'b0, a_off); // analog running
      check_bit("oe_idle", 1'b0, dout_oe); // not selected
      #1 check_bit("mclk_low", ~clk_sys_i, mclk); // inverted clock
      #10 check_bit("mclk_high", ~clk_sys_i, mclk); // inverted clock
      for (int i = 0; i < 16; i++)
      begin
        @(posedge clk_sys_i);
        pseudo <= i[3];
        chan <= i[2:0];
        cyc(2);
        @(negedge clk_sys_i);
        check_vec("mux", {12'h000, exp_mux(i[3], i[2:0])}, {12'h000, pos, neg});
      end
      for (int k = 0; k < 3; k++)
      begin
        w = (k == 0) ? 24'h800001 : (k == 1) ? 24'h7ffffe : 24'($urandom);
        put_word(w);
        check_bit("ready_new", 1'b0, ready_n); // new word
        read_word(w);
      end
      put_word(w);
      @(posedge clk_sys_i) align_n <= 1'b0;
      cyc(4);
      @(negedge clk_sys_i);
      check_vec("holds", 24'h00000f, {20'h00000, f_rst, fc_rst, cal_rst, mod_rst});
      check_bit("ready_align", 1'b0, ready_n); // ready kept low
      read_word(w); // serial side untouched
      @(posedge clk_sys_i) align_n <= 1'b1;
      @(posedge clk_sys_i) sleep_n <= 1'b0;
      cyc(4);
      put_word(24'($urandom));
      check_bit("a_off", 1'b1, a_off); // analog shut down
      check_bit("d_off", 1'b1, d_off); // digital shut down
      check_bit("ready_sleep", 1'b1, ready_n); // result dropped
      @(posedge clk_sys_i) sleep_n <= 1'b1;
      cyc(4);
    end
    end_of_test();
  end
endmodule

`default_nettype wire
